// *** rtl/ppm_pin_cell.sv ***
// One pin's priority mux between segment, peripheral and port drive
`default_nettype none
module ppm_pin_cell (
	input  wire logic seg_en,
	input  wire logic seg_val,
	input  wire logic periph_en,
	input  wire logic periph_oe,
	input  wire logic periph_val,
	input  wire logic dir_in,
	input  wire logic latch_val,
	input  wire logic open_drain,
	output logic      pin_o,
	output logic      pin_oe,
	output logic      digital_ok
);
	always_comb begin
		if (seg_en) begin
			pin_o      = seg_val;
			pin_oe     = 1'b1;
			digital_ok = 1'b0;
		end else if (periph_en) begin
			pin_o      = periph_val;
			pin_oe     = periph_oe & ~(open_drain & periph_val);
			digital_ok = 1'b1;
		end else begin
			pin_o      = latch_val;
			pin_oe     = ~dir_in & ~(open_drain & latch_val);
			digital_ok = 1'b1;
		end
	end
endmodule : ppm_pin_cell
`default_nettype wire

// *** rtl/ppm_pkg.sv ***
// Package of constants and types for the port pin function mux
`default_nettype none
// Contract
// - An enabled LCD segment function owns the pin and disables every other function there.
// - In synchronous serial mode the serial data output drives the pin ahead of the latch even with direction 1.
// - The asynchronous serial receiver takes the pin level through a Schmitt buffer while direction is 1.
// - With direction 0 a capture/compare/PWM output drives the pin, with direction 1 the pin feeds its capture input.
// - Enhanced-PWM outputs drive their pins at direction 0 and can be set to tri-state during enhanced PWM.
// - After reset analog-shared pins default to analog and analog selection leaves the digital input path alone.
// - A comparator input receives the pin level whatever the direction bit says.
// - On small-package variants the upper bits of segment enable 4 are not implemented and read as 0.
package ppm_pkg;
	localparam logic [7:0] PPM_OFF_PORT_C_LEVELS  = 8'h00;
	localparam logic [7:0] PPM_OFF_PORT_C_LATCH   = 8'h04;
	localparam logic [7:0] PPM_OFF_PORT_C_DIR     = 8'h08;
	localparam logic [7:0] PPM_OFF_SEG_EN_1       = 8'h0c;
	localparam logic [7:0] PPM_OFF_SEG_EN_2       = 8'h10;
	localparam logic [7:0] PPM_OFF_SEG_EN_3       = 8'h14;
	localparam logic [7:0] PPM_OFF_SEG_EN_4       = 8'h18;
	localparam logic [7:0] PPM_OFF_OPEN_DRAIN_1   = 8'h1c;
	localparam logic [7:0] PPM_OFF_PORT_H_LEVELS  = 8'h20;
	localparam logic [7:0] PPM_OFF_PORT_H_LATCH   = 8'h24;
	localparam logic [7:0] PPM_OFF_PORT_H_DIR     = 8'h28;
	localparam logic [7:0] PPM_OFF_SEG_EN_5       = 8'h2c;
	localparam logic [7:0] PPM_OFF_ANALOG_SEL_1   = 8'h30;
	localparam logic [7:0] PPM_OFF_ANALOG_SEL_2   = 8'h34;
	localparam logic [7:0] PPM_OFF_OPEN_DRAIN_2   = 8'h38;
	localparam logic [7:0] PPM_OFF_FUNC_CTRL      = 8'h3c;
	localparam logic [7:0] PPM_OFF_FUNC_STATUS    = 8'h40;
	localparam logic [7:0] PPM_RST_DIR            = 8'hff;
	localparam logic [7:0] PPM_RST_ZERO           = 8'h00;
	localparam logic [7:0] PPM_RST_ANALOG         = 8'hff;
	localparam logic [7:0] PPM_SE4_SMALL_MASK     = 8'h01;
	localparam logic [7:0] PPM_SE4_FULL_MASK      = 8'hff;
	localparam int         PPM_BIT_C7             = 7;
	localparam int         PPM_BIT_H6             = 6;
	localparam int         PPM_BIT_H7             = 7;
	localparam int         PPM_SE3_BIT_LCD_SEGMENT_28_OUT      = 4;
	localparam int         PPM_SE5_BIT_LCD_SEGMENT_42_OUT      = 2;
	localparam int         PPM_SE5_BIT_LCD_SEGMENT_43_OUT      = 3;
	localparam int         PPM_AN1_BIT_CH14       = 6;
	localparam int         PPM_AN1_BIT_CH15       = 7;
	localparam int         PPM_CTL_SYNC_MODE      = 0;
	localparam int         PPM_CTL_CH7_ACTIVE     = 1;
	localparam int         PPM_CTL_CH6_ACTIVE     = 2;
	localparam int         PPM_CTL_EPWM_C_ACTIVE  = 3;
	localparam int         PPM_CTL_EPWM_B_ACTIVE  = 4;
	localparam int         PPM_CTL_EPWM_TRISTATE  = 5;

	// Per-pin sources from the peripherals
	typedef struct packed {
		logic sync_mode;
		logic sync_data_out;
		logic sync_data_oe;
		logic capture_compare_pwm_ch7_out;
		logic capture_compare_pwm_ch6_out;
		logic epwm_c_out;
		logic epwm_b_out;
		logic epwm_tristate;
		logic lcd_segment_28_out;
		logic lcd_segment_42_out;
		logic lcd_segment_43_out;
	} ppm_periph_t;

	// Per-pin inputs delivered to the peripherals
	typedef struct packed {
		logic async_rx;
		logic sync_data_in;
		logic capture_compare_pwm_ch7_capture;
		logic capture_compare_pwm_ch6_capture;
		logic analog_ch14;
		logic analog_ch15;
		logic comp1_in_c;
	} ppm_taps_t;
endpackage : ppm_pkg
`default_nettype wire

// *** rtl/ppm_port_mux.sv ***
// Top of the port C and port H pin function mux with Wishbone registers
`default_nettype none
module ppm_port_mux #(
	parameter bit SMALL_PACKAGE = 1'b0
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [31:0]      wb_dat_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic             wb_we_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	output logic                  wb_err_o,
	input  wire ppm_pkg::ppm_periph_t periph_i,
	input  wire logic [7:0]       port_c_pin_i,
	output logic      [7:0]       port_c_pin_o,
	output logic      [7:0]       port_c_pin_oe,
	input  wire logic [7:0]       port_h_pin_i,
	output logic      [7:0]       port_h_pin_o,
	output logic      [7:0]       port_h_pin_oe,
	output ppm_pkg::ppm_taps_t    taps_o
);
	import ppm_pkg::*;

	logic [7:0] c_lat_q, c_dir_q, h_lat_q, h_dir_q;
	logic [7:0] se1_q, se2_q, se3_q, se4_q, se5_q;
	logic [7:0] an1_q, an2_q, od1_q, od2_q, ctl_q;
	logic [7:0] c_in_q, h_in_q;
	logic [7:0] c_o_d, c_oe_d, h_o_d, h_oe_d, c_dig, h_dig;
	logic [7:0] c_pen, c_poe, c_pval, h_pen, h_poe, h_pval;
	logic [7:0] c_seg, c_segv, h_seg, h_segv;
	logic [7:0] se4_mask;
	logic [7:0] rd_d;
	logic       hit_d;
	logic       wr_stb, req;
	ppm_taps_t  taps_d;

	assign se4_mask = SMALL_PACKAGE ? PPM_SE4_SMALL_MASK : PPM_SE4_FULL_MASK;

	assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr_stb = req & wb_we_i & wb_sel_i[0];

	function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] off);
		wr_hit = (adr == off);
	endfunction : wr_hit

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			c_lat_q <= PPM_RST_ZERO;
			h_lat_q <= PPM_RST_ZERO;
		end else if (wr_stb) begin
			if (wr_hit(wb_adr_i, PPM_OFF_PORT_C_LATCH) || wr_hit(wb_adr_i, PPM_OFF_PORT_C_LEVELS)) begin
				c_lat_q <= wb_dat_i[7:0];
			end else if (wr_hit(wb_adr_i, PPM_OFF_PORT_H_LATCH) || wr_hit(wb_adr_i, PPM_OFF_PORT_H_LEVELS)) begin
				h_lat_q <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			c_dir_q <= PPM_RST_DIR;
			h_dir_q <= PPM_RST_DIR;
			ctl_q   <= PPM_RST_ZERO;
		end else if (wr_stb) begin
			if (wr_hit(wb_adr_i, PPM_OFF_PORT_C_DIR)) begin
				c_dir_q <= wb_dat_i[7:0];
			end else if (wr_hit(wb_adr_i, PPM_OFF_PORT_H_DIR)) begin
				h_dir_q <= wb_dat_i[7:0];
			end else if (wr_hit(wb_adr_i, PPM_OFF_FUNC_CTRL)) begin
				ctl_q <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			se1_q <= PPM_RST_ZERO;
			se2_q <= PPM_RST_ZERO;
			se3_q <= PPM_RST_ZERO;
			se4_q <= PPM_RST_ZERO;
			se5_q <= PPM_RST_ZERO;
		end else if (wr_stb) begin
			if (wr_hit(wb_adr_i, PPM_OFF_SEG_EN_1)) begin
				se1_q <= wb_dat_i[7:0];
			end else if (wr_hit(wb_adr_i, PPM_OFF_SEG_EN_2)) begin
				se2_q <= wb_dat_i[7:0];
			end else if (wr_hit(wb_adr_i, PPM_OFF_SEG_EN_3)) begin
				se3_q <= wb_dat_i[7:0];
			end else if (wr_hit(wb_adr_i, PPM_OFF_SEG_EN_4)) begin
				se4_q <= wb_dat_i[7:0] & se4_mask;
			end else if (wr_hit(wb_adr_i, PPM_OFF_SEG_EN_5)) begin
				se5_q <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			an1_q <= PPM_RST_ANALOG;
			an2_q <= PPM_RST_ANALOG;
		end else if (wr_stb) begin
			if (wr_hit(wb_adr_i, PPM_OFF_ANALOG_SEL_1)) begin
				an1_q <= wb_dat_i[7:0];
			end else if (wr_hit(wb_adr_i, PPM_OFF_ANALOG_SEL_2)) begin
				an2_q <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			od1_q <= PPM_RST_ZERO;
			od2_q <= PPM_RST_ZERO;
		end else if (wr_stb) begin
			if (wr_hit(wb_adr_i, PPM_OFF_OPEN_DRAIN_1)) begin
				od1_q <= wb_dat_i[7:0];
			end else if (wr_hit(wb_adr_i, PPM_OFF_OPEN_DRAIN_2)) begin
				od2_q <= wb_dat_i[7:0];
			end
		end
	end

	// Pin levels are sampled once so reads and peripheral taps agree
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			c_in_q <= PPM_RST_ZERO;
			h_in_q <= PPM_RST_ZERO;
		end else begin
			c_in_q <= port_c_pin_i;
			h_in_q <= port_h_pin_i;
		end
	end

	// Peripheral overrides per pin
	always_comb begin
		c_pen  = '0;
		c_poe  = '0;
		c_pval = '0;
		h_pen  = '0;
		h_poe  = '0;
		h_pval = '0;
		c_seg  = '0;
		c_segv = '0;
		h_seg  = '0;
		h_segv = '0;
		c_seg[PPM_BIT_C7]  = se3_q[PPM_SE3_BIT_LCD_SEGMENT_28_OUT];
		c_segv[PPM_BIT_C7] = periph_i.lcd_segment_28_out;
		h_seg[PPM_BIT_H6]  = se5_q[PPM_SE5_BIT_LCD_SEGMENT_42_OUT];
		h_segv[PPM_BIT_H6] = periph_i.lcd_segment_42_out;
		h_seg[PPM_BIT_H7]  = se5_q[PPM_SE5_BIT_LCD_SEGMENT_43_OUT];
		h_segv[PPM_BIT_H7] = periph_i.lcd_segment_43_out;
		if (periph_i.sync_mode && ctl_q[PPM_CTL_SYNC_MODE] && periph_i.sync_data_oe) begin
			c_pen[PPM_BIT_C7]  = 1'b1;
			c_poe[PPM_BIT_C7]  = 1'b1;
			c_pval[PPM_BIT_C7] = periph_i.sync_data_out;
		end
		if (ctl_q[PPM_CTL_CH7_ACTIVE] && !h_dir_q[PPM_BIT_H6]) begin
			h_pen[PPM_BIT_H6]  = 1'b1;
			h_poe[PPM_BIT_H6]  = 1'b1;
			h_pval[PPM_BIT_H6] = periph_i.capture_compare_pwm_ch7_out;
		end else if (ctl_q[PPM_CTL_EPWM_C_ACTIVE] && !h_dir_q[PPM_BIT_H6]) begin
			h_pen[PPM_BIT_H6]  = 1'b1;
			h_poe[PPM_BIT_H6]  = ~(ctl_q[PPM_CTL_EPWM_TRISTATE] & periph_i.epwm_tristate);
			h_pval[PPM_BIT_H6] = periph_i.epwm_c_out;
		end
		if (ctl_q[PPM_CTL_CH6_ACTIVE] && !h_dir_q[PPM_BIT_H7]) begin
			h_pen[PPM_BIT_H7]  = 1'b1;
			h_poe[PPM_BIT_H7]  = 1'b1;
			h_pval[PPM_BIT_H7] = periph_i.capture_compare_pwm_ch6_out;
		end else if (ctl_q[PPM_CTL_EPWM_B_ACTIVE] && !h_dir_q[PPM_BIT_H7]) begin
			h_pen[PPM_BIT_H7]  = 1'b1;
			h_poe[PPM_BIT_H7]  = ~(ctl_q[PPM_CTL_EPWM_TRISTATE] & periph_i.epwm_tristate);
			h_pval[PPM_BIT_H7] = periph_i.epwm_b_out;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			ppm_pin_cell u_c (
				.seg_en     (c_seg[gi]),
				.seg_val    (c_segv[gi]),
				.periph_en  (c_pen[gi]),
				.periph_oe  (c_poe[gi]),
				.periph_val (c_pval[gi]),
				.dir_in     (c_dir_q[gi]),
				.latch_val  (c_lat_q[gi]),
				.open_drain (od1_q[gi]),
				.pin_o      (c_o_d[gi]),
				.pin_oe     (c_oe_d[gi]),
				.digital_ok (c_dig[gi])
			);
			ppm_pin_cell u_h (
				.seg_en     (h_seg[gi]),
				.seg_val    (h_segv[gi]),
				.periph_en  (h_pen[gi]),
				.periph_oe  (h_poe[gi]),
				.periph_val (h_pval[gi]),
				.dir_in     (h_dir_q[gi]),
				.latch_val  (h_lat_q[gi]),
				.open_drain (od2_q[gi]),
				.pin_o      (h_o_d[gi]),
				.pin_oe     (h_oe_d[gi]),
				.digital_ok (h_dig[gi])
			);
		end
	endgenerate

	// Peripheral input taps; a segment pin blanks every digital tap
	always_comb begin
		taps_d = '0;
		taps_d.async_rx     = c_dig[PPM_BIT_C7] & c_dir_q[PPM_BIT_C7] & c_in_q[PPM_BIT_C7];
		taps_d.sync_data_in = c_dig[PPM_BIT_C7] & c_dir_q[PPM_BIT_C7] & c_in_q[PPM_BIT_C7];
		taps_d.capture_compare_pwm_ch7_capture = h_dig[PPM_BIT_H6] & h_dir_q[PPM_BIT_H6] & h_in_q[PPM_BIT_H6];
		taps_d.capture_compare_pwm_ch6_capture = h_dig[PPM_BIT_H7] & h_dir_q[PPM_BIT_H7] & h_in_q[PPM_BIT_H7];
		taps_d.analog_ch14  = h_dig[PPM_BIT_H6] & an1_q[PPM_AN1_BIT_CH14] & h_in_q[PPM_BIT_H6];
		taps_d.analog_ch15  = h_dig[PPM_BIT_H7] & an1_q[PPM_AN1_BIT_CH15] & h_in_q[PPM_BIT_H7];
		taps_d.comp1_in_c   = h_dig[PPM_BIT_H6] & h_in_q[PPM_BIT_H6];
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			port_c_pin_o  <= PPM_RST_ZERO;
			port_c_pin_oe <= PPM_RST_ZERO;
			port_h_pin_o  <= PPM_RST_ZERO;
			port_h_pin_oe <= PPM_RST_ZERO;
			taps_o        <= '0;
		end else begin
			port_c_pin_o  <= c_o_d;
			port_c_pin_oe <= c_oe_d;
			port_h_pin_o  <= h_o_d;
			port_h_pin_oe <= h_oe_d;
			taps_o        <= taps_d;
		end
	end

	// Read decode; digital input of analog pins still reads the pin level
	always_comb begin
		rd_d  = '0;
		hit_d = 1'b1;
		if (wb_adr_i == PPM_OFF_PORT_C_LEVELS) begin
			rd_d = c_in_q;
		end else if (wb_adr_i == PPM_OFF_PORT_C_LATCH) begin
			rd_d = c_lat_q;
		end else if (wb_adr_i == PPM_OFF_PORT_C_DIR) begin
			rd_d = c_dir_q;
		end else if (wb_adr_i == PPM_OFF_SEG_EN_1) begin
			rd_d = se1_q;
		end else if (wb_adr_i == PPM_OFF_SEG_EN_2) begin
			rd_d = se2_q;
		end else if (wb_adr_i == PPM_OFF_SEG_EN_3) begin
			rd_d = se3_q;
		end else if (wb_adr_i == PPM_OFF_SEG_EN_4) begin
			rd_d = se4_q & se4_mask;
		end else if (wb_adr_i == PPM_OFF_OPEN_DRAIN_1) begin
			rd_d = od1_q;
		end else if (wb_adr_i == PPM_OFF_PORT_H_LEVELS) begin
			rd_d = h_in_q;
		end else if (wb_adr_i == PPM_OFF_PORT_H_LATCH) begin
			rd_d = h_lat_q;
		end else if (wb_adr_i == PPM_OFF_PORT_H_DIR) begin
			rd_d = h_dir_q;
		end else if (wb_adr_i == PPM_OFF_SEG_EN_5) begin
			rd_d = se5_q;
		end else if (wb_adr_i == PPM_OFF_ANALOG_SEL_1) begin
			rd_d = an1_q;
		end else if (wb_adr_i == PPM_OFF_ANALOG_SEL_2) begin
			rd_d = an2_q;
		end else if (wb_adr_i == PPM_OFF_OPEN_DRAIN_2) begin
			rd_d = od2_q;
		end else if (wb_adr_i == PPM_OFF_FUNC_CTRL) begin
			rd_d = ctl_q;
		end else if (wb_adr_i == PPM_OFF_FUNC_STATUS) begin
			rd_d = {c_oe_d[PPM_BIT_C7], h_oe_d[PPM_BIT_H7], h_oe_d[PPM_BIT_H6], 2'b00,
			        ~c_dig[PPM_BIT_C7], ~h_dig[PPM_BIT_H7], ~h_dig[PPM_BIT_H6]};
		end else begin
			hit_d = 1'b0;
		end
	end

	// One wait-free answer per request; unmapped addresses answer with err
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req & hit_d;
			wb_err_o <= req & ~hit_d;
			wb_dat_o <= {24'h00_0000, (req & hit_d & ~wb_we_i) ? rd_d : 8'h00};
		end
	end
endmodule : ppm_port_mux
`default_nettype wire

// *** test/ppm_board.sv ***
// Board model: pull-ups plus an optional external driver per pin
`default_nettype none
module ppm_board (
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released pins follow the external driver, or the pull-up when none
	assign pin_i = (pin_o & pin_oe) | (~pin_oe & ((ext_val & ext_en) | ~ext_en));
endmodule : ppm_board
`default_nettype wire

// *** test/ppm_port_mux_props.sv ***
// Port checker for the pin function mux
`default_nettype none
module ppm_port_mux_props
	import ppm_pkg::*;
#(
	parameter bit SMALL_PACKAGE = 1'b0
) (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_we_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire ppm_periph_t periph_i,
	input wire logic [7:0]  port_c_pin_o,
	input wire logic [7:0]  port_c_pin_oe,
	input wire logic [7:0]  port_h_pin_i,
	input wire logic [7:0]  port_h_pin_o,
	input wire logic [7:0]  port_h_pin_oe,
	input wire ppm_taps_t   taps_o
);
	logic [7:0] ctl_q, se3_q, se5_q, dirh_q;
	logic       wr;
	// Shadows store on the edge that takes the request, as the slave does
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && !wb_err_o;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctl_q <= 8'h00;
			se3_q <= 8'h00;
			se5_q <= 8'h00;
			dirh_q <= 8'hff;
		end else if (wr) begin
			if (wb_adr_i == PPM_OFF_FUNC_CTRL) ctl_q <= wb_dat_i[7:0];
			if (wb_adr_i == PPM_OFF_SEG_EN_3) se3_q <= wb_dat_i[7:0];
			if (wb_adr_i == PPM_OFF_SEG_EN_5) se5_q <= wb_dat_i[7:0];
			if (wb_adr_i == PPM_OFF_PORT_H_DIR) dirh_q <= wb_dat_i[7:0];
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_done;
		(wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o);
	endsequence
	a_bus_answer_next: assert property (s_req |=> s_done)
		else $error("bus answer missing or too long");
	a_seg_owns_pin: assert property ($past(rst_n && se5_q[2]) |->
		port_h_pin_oe[6] && port_h_pin_o[6] == $past(periph_i.lcd_segment_42_out))
		else $error("segment does not own pin");
	a_seg_blanks_taps: assert property ($past(rst_n && se5_q[2]) && $past(se5_q[2], 2) |->
		!(taps_o.capture_compare_pwm_ch7_capture || taps_o.analog_ch14 || taps_o.comp1_in_c))
		else $error("segment pin still feeds inputs");
	a_sync_data_wins: assert property ($past(rst_n && ctl_q[0] && periph_i.sync_mode &&
		periph_i.sync_data_oe && !se3_q[4]) |-> port_c_pin_oe[7] && port_c_pin_o[7] == $past(periph_i.sync_data_out))
		else $error("sync data not on pin");
	a_ccp_out_wins: assert property ($past(rst_n && ctl_q[1] && !dirh_q[6] && !se5_q[2]) |->
		port_h_pin_oe[6] && port_h_pin_o[6] == $past(periph_i.capture_compare_pwm_ch7_out))
		else $error("compare output not on pin");
	a_epwm_hiz: assert property ($past(rst_n && ctl_q[3] && ctl_q[5] && !ctl_q[1] &&
		periph_i.epwm_tristate && !se5_q[2]) |-> !port_h_pin_oe[6])
		else $error("pwm pin not tri-stated");
	a_dir_releases: assert property ($past(rst_n && dirh_q[7] && !se5_q[3] && !ctl_q[2] && !ctl_q[4]) |->
		!port_h_pin_oe[7])
		else $error("input pin still driven");
	a_comp_direct: assert property ($past(rst_n && !se5_q[2]) && $past(rst_n && !se5_q[2], 2) |->
		taps_o.comp1_in_c == $past(port_h_pin_i[6], 2))
		else $error("comparator tap wrong");
endmodule : ppm_port_mux_props
bind ppm_port_mux ppm_port_mux_props #(.SMALL_PACKAGE(SMALL_PACKAGE)) i_props (.*);
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the port pin function mux
`default_nettype none
module tb_top;
	import ppm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, er;
	logic [7:0]  wb_adr_i, port_c_pin_i, port_c_pin_o, port_c_pin_oe, c_en, c_val, r, a;
	logic [7:0]  port_h_pin_i, port_h_pin_o, port_h_pin_oe, h_en, h_val;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0]  wb_sel_i;
	ppm_periph_t periph_i;
	ppm_taps_t   taps_o;
	int          fail_count, n_tests, seed, mdl[int];
	ppm_port_mux #(.SMALL_PACKAGE(1'b1)) i_dut (.*);
	ppm_board i_bc (.pin_o(port_c_pin_o), .pin_oe(port_c_pin_oe), .ext_en(c_en), .ext_val(c_val), .pin_i(port_c_pin_i));
	ppm_board i_bh (.pin_o(port_h_pin_o), .pin_oe(port_h_pin_oe), .ext_en(h_en), .ext_val(h_val), .pin_i(port_h_pin_i));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic [7:0] ad, input logic we, input logic [7:0] d, input logic [3:0] s);
		int n;
		n = 0;
		wb_adr_i <= ad;
		wb_we_i <= we;
		wb_dat_i <= {24'h00_0000, d};
		wb_sel_i <= s;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (!(wb_ack_o || wb_err_o) && n < 50);
		if (n >= 50) fail_count++;
		rd = wb_dat_o;
		er = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask : wb
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		wb(ad, 1'b1, d, 4'h1);
	endtask : wr
	task automatic st();
		repeat (3) @(posedge core_clk);
	endtask : st
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end
	initial begin
		seed = 62021;
		{fail_count, n_tests} = '0;
		{rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
		{periph_i, c_en, c_val, h_en, h_val} = '0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		// Reset values, then random write and refused write per register from 0x04 to 0x3c; open-drain registers get the reset check only, 0x20 none
		for (int i = 1; i < 16; i++) begin
			a = 8'(4 * i);
			mdl[a] = (a == 8'h08 || a == 8'h28 || a == 8'h30 || a == 8'h34) ? 255 : 0;
			if (a == 8'h20) continue;
			wb(a, 1'b0, 8'h00, 4'hf);
			chk(rd, mdl[a]);
			if (a == 8'h1c || a == 8'h38) continue;
			r = 8'($random(seed));
			wb(a, 1'b1, r, 4'hf);
			mdl[a] = (a == 8'h18) ? (r & 8'h01) : r;
			wb(a, 1'b1, ~r, 4'he);
			wb(a, 1'b0, 8'h00, 4'hf);
			chk(rd, mdl[a]);
		end
		wb(8'h80, 1'b0, 8'h00, 4'hf);
		chk(er, 1'b1);
		wr(8'h3c, 8'h00);
		wr(8'h14, 8'h00);
		wr(8'h2c, 8'h00);
		r = 8'($random(seed));
		wr(8'h04, r);
		wr(8'h08, 8'h00);
		st();
		chk({port_c_pin_oe, port_c_pin_o}, {8'hff, r});
		c_en <= 8'hff;
		c_val <= 8'($random(seed));
		wr(8'h08, 8'hff);
		st();
		wb(8'h00, 1'b0, 8'h00, 4'hf);
		chk({port_c_pin_oe, rd}, {8'h00, 24'h00_0000, c_val});
		chk(taps_o.async_rx, c_val[7]);
		chk(taps_o.sync_data_in, c_val[7]);
		periph_i.sync_mode <= 1'b1;
		periph_i.sync_data_oe <= 1'b1;
		wr(8'h3c, 8'h01);
		for (int b = 0; b < 2; b++) begin
			periph_i.sync_data_out <= b[0];
			st();
			chk({port_c_pin_oe[7], port_c_pin_o[7]}, {1'b1, b[0]});
		end
		r = 8'($random(seed));
		{periph_i.lcd_segment_28_out, periph_i.lcd_segment_42_out, periph_i.lcd_segment_43_out} <= r[2:0];
		wr(8'h14, 8'h10);
		wr(8'h2c, 8'h0c);
		st();
		chk({port_c_pin_oe[7], port_h_pin_oe[7:6], port_c_pin_o[7], port_h_pin_o[6], port_h_pin_o[7]}, {3'h7, r[2:0]});
		chk(taps_o.async_rx, 1'b0);
		wb(8'h40, 1'b0, 8'h00, 4'hf);
		chk(rd, 32'h0000_00e7);
		wr(8'h14, 8'h00);
		wr(8'h2c, 8'h00);
		// One assignment so the struct changes once in this step
		periph_i <= ppm_periph_t'(11'h080);
		wr(8'h24, 8'h00);
		wr(8'h28, 8'h00);
		wr(8'h3c, 8'h02);
		st();
		chk({port_h_pin_oe[6], port_h_pin_o[6]}, 2'h3);
		h_en <= 8'hff;
		h_val <= 8'($random(seed));
		wr(8'h30, 8'hff);
		wr(8'h28, 8'hff);
		st();
		chk(taps_o.capture_compare_pwm_ch7_capture, h_val[6]);
		chk(taps_o.capture_compare_pwm_ch6_capture, h_val[7]);
		chk(taps_o.analog_ch15, h_val[7]);
		chk(taps_o.analog_ch14, h_val[6]);
		chk(taps_o.comp1_in_c, h_val[6]);
		wb(8'h20, 1'b0, 8'h00, 4'hf);
		chk(rd, {24'h00_0000, h_val});
		periph_i <= ppm_periph_t'(11'h008);
		wr(8'h28, 8'h00);
		wr(8'h3c, 8'h28);
		st();
		chk(port_h_pin_oe[6], 1'b0);
		periph_i <= ppm_periph_t'(11'h020);
		st();
		chk({port_h_pin_oe[6], port_h_pin_o[6]}, 2'h3);
		wr(8'h3c, 8'h00);
		wr(8'h24, 8'h40);
		st();
		chk(taps_o.comp1_in_c, 1'b1);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
